// ---- rtl/pcaer_pkg.sv ----
// Operation
// [RQ1] Mask bit 19 blocks ECRC logging and message.
// [RQ2] Mask bit 20 blocks UR; bits 31:21 zero.
// [RQ3] Severity bit: zero non-fatal, one fatal.
// [RQ4] Severity reset values; reserved bits read zero.
// [RQ5] Receiver error sets status bit 0, W1C.
// [RQ6] Bad TLP bit 6, bad DLLP bit 7.
// [RQ7] Rollover bit 8, replay timeout bit 12.
// [RQ8] Correctable mask 0,6,7 block log and message.
// [RQ9] Correctable mask 8,12 block log and message.
// [RQ10] First error pointer holds first uncorrectable position.
// [RQ11] ECRC generation capable reads one.
// [RQ12] Bit 6 enables ECRC generation, reset off.
// [RQ13] ECRC check capable reads one.
// [RQ14] Bit 8 enables ECRC check; 31:9 zero.
// [RQ15] Logged error captures four header dwords, big-endian.
// [RQ16] Sticky fields survive link reset, cleared at power-on.
package pcaer_pkg;
	localparam logic [11:0] OFF_UNC_MASK = 12'h108;
	localparam logic [11:0] OFF_UNC_SEV = 12'h10c;
	localparam logic [11:0] OFF_COR_STS = 12'h110;
	localparam logic [11:0] OFF_COR_MASK = 12'h114;
	localparam logic [11:0] OFF_CAP_CTRL = 12'h118;
	localparam logic [11:0] OFF_HDR0 = 12'h11c;
	localparam logic [11:0] OFF_HDR1 = 12'h120;
	localparam logic [11:0] OFF_HDR2 = 12'h124;
	localparam logic [11:0] OFF_HDR3 = 12'h128;
	localparam logic [11:0] OFF_LOG_LOCK = 12'h130;
	localparam logic [11:0] OFF_IRQ_STS = 12'h134;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h138;
	localparam logic [20:0] UNC_BITS = 21'h1f_f011;
	localparam logic [20:0] UNC_SEV_RST = 21'h06_2011;
	localparam int UNC_ECRC_BIT = 19;
	localparam logic [12:0] COR_BITS = 13'h11c1;
	localparam int CAP_FEP_LSB = 0;
	localparam int CAP_GEN_CAP = 5;
	localparam int CAP_GEN_EN = 6;
	localparam int CAP_CHK_CAP = 7;
	localparam int CAP_CHK_EN = 8;
	localparam int IRQ_COR = 0;
	localparam int IRQ_UNC = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		PCAER_MSG_COR = 2'h0,
		PCAER_MSG_NONFATAL = 2'h1,
		PCAER_MSG_FATAL = 2'h3
	} pcaer_msg_e;
	typedef struct packed {
		logic [20:0] unc_mask;
		logic [20:0] unc_sev;
		logic [12:0] cor_sts;
		logic [12:0] cor_mask;
		logic [4:0] fep;
		logic gen_en;
		logic chk_en;
		logic lock;
		logic [3:0][31:0] hdr;
		logic [1:0] irq_sts;
		logic [1:0] irq_mask;
		logic irq;
		logic msg_valid;
		pcaer_msg_e msg_type;
		logic aw_ok;
		logic w_ok;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pcaer_state_s;
	localparam pcaer_state_s STATE_RST = '{
		unc_sev: UNC_SEV_RST,
		msg_type: PCAER_MSG_COR,
		default: '0
	};
endpackage : pcaer_pkg

// ---- rtl/pcaer_top.sv ----
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
module pcaer_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic link_reset,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [20:0] unc_event,
	input wire logic [12:0] cor_event,
	input wire logic [127:0] err_header,
	output logic msg_valid,
	output logic [1:0] msg_type,
	output logic ecrc_gen_en,
	output logic ecrc_chk_en,
	output logic irq
);
	pcaer_pkg::pcaer_state_s s_q;
	pcaer_pkg::pcaer_state_s s_d;

	// Byte lanes without a strobe keep their old value.
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// Only strobed lanes may clear a write-one-to-clear bit.
	function automatic logic [31:0] lanes(
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction : lanes

	// The scan runs downwards, so the lowest set position is the one left.
	function automatic logic [4:0] first_bit(
		input logic [20:0] v
	);
		logic [4:0] r;
		r = '0;
		for (int i = 20; i >= 0; i--)
		begin
			if (v[i])
			begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : first_bit

	////////////////////////////////////////////////////////////////////////////////

	logic [20:0] unc_det;
	logic [20:0] unc_hit;
	logic [12:0] cor_det;
	logic [12:0] cor_hit;
	logic do_write;
	logic do_read;
	logic [31:0] wm;
	logic [31:0] w1c;
	logic [11:0] waddr;
	logic [11:0] raddr;
	logic [31:0] cap_word;
	logic log_now;
	logic [20:0] unc_fatal;
	logic [20:0] unc_nonfatal;

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		s_d = s_q;
		// Event inputs are sampled every cycle; a level held high reports every cycle.
		unc_det = unc_event & pcaer_pkg::UNC_BITS;
		// An ECRC error cannot be detected while checking is off.
		unc_det[pcaer_pkg::UNC_ECRC_BIT] = unc_det[pcaer_pkg::UNC_ECRC_BIT] & s_q.chk_en; // RQ14
		// Masked errors are neither logged nor reported.
		unc_hit = unc_det & ~s_q.unc_mask; // RQ1 RQ2
		unc_fatal = unc_hit & s_q.unc_sev; // RQ3
		unc_nonfatal = unc_hit & ~s_q.unc_sev; // RQ3
		// Correctable status is kept even while masked; only the header log and the report are held back.
		cor_det = cor_event & pcaer_pkg::COR_BITS;
		cor_hit = cor_det & ~s_q.cor_mask; // RQ8 RQ9
		log_now = (|unc_hit || |cor_hit) && !s_q.lock;
		// The capability bits are constant ones; the enables live in sticky flops.
		cap_word = '0;
		cap_word[pcaer_pkg::CAP_FEP_LSB +: 5] = s_q.fep;
		cap_word[pcaer_pkg::CAP_GEN_CAP] = 1'b1; // RQ11
		cap_word[pcaer_pkg::CAP_GEN_EN] = s_q.gen_en;
		cap_word[pcaer_pkg::CAP_CHK_CAP] = 1'b1; // RQ13
		cap_word[pcaer_pkg::CAP_CHK_EN] = s_q.chk_en;

		// Write channel: address and data are taken in either order.
		if (s_q.awready && s_axi_awvalid)
		begin
			s_d.aw_ok = 1'b1;
			s_d.awaddr = {s_axi_awaddr[11:2], 2'b00};
		end
		if (s_q.wready && s_axi_wvalid)
		begin
			s_d.w_ok = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
		end
		// A write is applied once both halves are in and the last response has gone.
		do_write = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
		waddr = s_q.awaddr;
		wm = '0;
		w1c = '0;
		if (do_write)
		begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = pcaer_pkg::RESP_OKAY;
			w1c = lanes(s_q.wdata, s_q.wstrb);
			case (waddr)
				pcaer_pkg::OFF_UNC_MASK:
				begin
					// Only implemented error positions keep a written one.
					wm = merge({11'h000, s_q.unc_mask}, s_q.wdata, s_q.wstrb);
					s_d.unc_mask = wm[20:0] & pcaer_pkg::UNC_BITS; // RQ2
				end
				pcaer_pkg::OFF_UNC_SEV:
				begin
					wm = merge({11'h000, s_q.unc_sev}, s_q.wdata, s_q.wstrb);
					s_d.unc_sev = wm[20:0] & pcaer_pkg::UNC_BITS; // RQ4
				end
				pcaer_pkg::OFF_COR_STS:
				begin
					s_d.cor_sts = s_q.cor_sts & ~w1c[12:0]; // RQ5 RQ6 RQ7
				end
				pcaer_pkg::OFF_COR_MASK:
				begin
					wm = merge({19'h0_0000, s_q.cor_mask}, s_q.wdata, s_q.wstrb);
					s_d.cor_mask = wm[12:0] & pcaer_pkg::COR_BITS;
				end
				pcaer_pkg::OFF_CAP_CTRL:
				begin
					// Only the two enables are writable here.
					wm = merge(cap_word, s_q.wdata, s_q.wstrb);
					s_d.gen_en = wm[pcaer_pkg::CAP_GEN_EN]; // RQ12
					s_d.chk_en = wm[pcaer_pkg::CAP_CHK_EN]; // RQ14
				end
				pcaer_pkg::OFF_HDR0, pcaer_pkg::OFF_HDR1,
				pcaer_pkg::OFF_HDR2, pcaer_pkg::OFF_HDR3:
				begin
					// The header log is read-only; a write is accepted and ignored.
					s_d.bresp = pcaer_pkg::RESP_OKAY;
				end
				pcaer_pkg::OFF_LOG_LOCK:
				begin
					s_d.lock = s_q.lock & ~w1c[0];
				end
				pcaer_pkg::OFF_IRQ_STS:
				begin
					s_d.irq_sts = s_q.irq_sts & ~w1c[1:0];
				end
				pcaer_pkg::OFF_IRQ_MASK:
				begin
					wm = merge({30'h0000_0000, s_q.irq_mask}, s_q.wdata, s_q.wstrb);
					s_d.irq_mask = wm[1:0];
				end
				default:
				begin
					// Unmapped offsets answer with an error and change nothing.
					s_d.bresp = pcaer_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Hardware events are applied after the clears, so a set wins.
		s_d.cor_sts = s_d.cor_sts | cor_det; // RQ5 RQ6 RQ7
		// The lock keeps the header of the first logged error until software frees it.
		if (log_now)
		begin
			s_d.lock = 1'b1;
			for (int i = 0; i < 4; i++)
			begin
				s_d.hdr[i] = err_header[127 - 32*i -: 32]; // RQ15
			end
			if (|unc_hit)
			begin
				s_d.fep = first_bit(unc_hit); // RQ10
			end
		end

		// One error message per cycle; the most severe pending class goes out.
		s_d.msg_valid = 1'b0;
		s_d.msg_type = pcaer_pkg::PCAER_MSG_COR;
		if (|unc_fatal)
		begin
			s_d.msg_valid = 1'b1; // RQ3
			s_d.msg_type = pcaer_pkg::PCAER_MSG_FATAL;
		end
		else if (|unc_nonfatal)
		begin
			s_d.msg_valid = 1'b1; // RQ3
			s_d.msg_type = pcaer_pkg::PCAER_MSG_NONFATAL;
		end
		else if (|cor_hit)
		begin
			s_d.msg_valid = 1'b1;
			s_d.msg_type = pcaer_pkg::PCAER_MSG_COR;
		end
		if (|unc_hit)
		begin
			s_d.irq_sts[pcaer_pkg::IRQ_UNC] = 1'b1;
		end
		if (|cor_hit)
		begin
			s_d.irq_sts[pcaer_pkg::IRQ_COR] = 1'b1;
		end

		// Link reset clears only the non-sticky state.
		// Sticky fields, the enables and the header log are left alone here.
		if (link_reset)
		begin
			s_d.irq_sts = '0; // RQ16
			s_d.irq_mask = '0;
			s_d.msg_valid = 1'b0;
		end
		s_d.irq = |(s_d.irq_sts & s_d.irq_mask);

		// Read channel.
		if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
		end
		// Read data is registered, so the answer stands one cycle after the address.
		do_read = s_q.arready && s_axi_arvalid;
		raddr = {s_axi_araddr[11:2], 2'b00};
		if (do_read)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = pcaer_pkg::RESP_OKAY;
			s_d.rdata = '0;
			case (raddr)
				pcaer_pkg::OFF_UNC_MASK:
				begin
					s_d.rdata = {11'h000, s_q.unc_mask}; // RQ2
				end
				pcaer_pkg::OFF_UNC_SEV:
				begin
					s_d.rdata = {11'h000, s_q.unc_sev}; // RQ4
				end
				pcaer_pkg::OFF_COR_STS:
				begin
					s_d.rdata = {19'h0_0000, s_q.cor_sts}; // RQ7
				end
				pcaer_pkg::OFF_COR_MASK:
				begin
					s_d.rdata = {19'h0_0000, s_q.cor_mask};
				end
				pcaer_pkg::OFF_CAP_CTRL:
				begin
					s_d.rdata = cap_word; // RQ14
				end
				pcaer_pkg::OFF_HDR0:
				begin
					s_d.rdata = s_q.hdr[0];
				end
				pcaer_pkg::OFF_HDR1:
				begin
					s_d.rdata = s_q.hdr[1];
				end
				pcaer_pkg::OFF_HDR2:
				begin
					s_d.rdata = s_q.hdr[2];
				end
				pcaer_pkg::OFF_HDR3:
				begin
					s_d.rdata = s_q.hdr[3];
				end
				pcaer_pkg::OFF_LOG_LOCK:
				begin
					s_d.rdata = {31'h0000_0000, s_q.lock};
				end
				pcaer_pkg::OFF_IRQ_STS:
				begin
					s_d.rdata = {30'h0000_0000, s_q.irq_sts};
				end
				pcaer_pkg::OFF_IRQ_MASK:
				begin
					s_d.rdata = {30'h0000_0000, s_q.irq_mask};
				end
				default:
				begin
					// Unmapped offsets read as zero with an error response.
					s_d.rresp = pcaer_pkg::RESP_SLVERR;
				end
			endcase
		end

		// A new request is accepted only once the previous answer has been taken.
		s_d.awready = !s_d.aw_ok && !s_d.bvalid;
		s_d.wready = !s_d.w_ok && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	////////////////////////////////////////////////////////////////////////////////

	// Power-on reset returns every field, sticky or not, to its default.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= pcaer_pkg::STATE_RST; // RQ16
		end
		else
		begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Every output comes straight from a flop of the state.
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign msg_valid = s_q.msg_valid;
	assign msg_type = s_q.msg_type;
	assign ecrc_gen_en = s_q.gen_en; // RQ12
	assign ecrc_chk_en = s_q.chk_en;
	assign irq = s_q.irq;
endmodule : pcaer_top

// ---- tb/pcaer_props.sv ----
`timescale 1ns/100ps
module pcaer_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [20:0] unc_event,
	input wire logic [12:0] cor_event,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic msg_valid,
	input wire logic [1:0] msg_type,
	input wire logic ecrc_gen_en,
	input wire logic ecrc_chk_en
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_msg_cause;
		msg_valid |-> $past(|unc_event || |cor_event);
	endproperty
	a_msg_cause: assert property (p_msg_cause) else $error("message without event");
	property p_cor_type;
		(unc_event == '0 && |cor_event) |=> !msg_valid || msg_type == 2'h0;
	endproperty
	a_cor_type: assert property (p_cor_type) else $error("bad correctable type");
	property p_unc_type;
		msg_valid && msg_type != 2'h0 |-> $past(|unc_event);
	endproperty
	a_unc_type: assert property (p_unc_type) else $error("bad uncorrectable type");
	property p_ecrc_off;
		(unc_event == 21'h8_0000 && cor_event == '0 && !ecrc_chk_en) ##1 !ecrc_chk_en
			|-> !msg_valid;
	endproperty
	a_ecrc_off: assert property (p_ecrc_off) else $error("ecrc reported unchecked");
	property p_gen_hold;
		$changed(ecrc_gen_en) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_gen_hold: assert property (p_gen_hold) else $error("gen enable moved");
	property p_chk_hold;
		$changed(ecrc_chk_en) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_chk_hold: assert property (p_chk_hold) else $error("check enable moved");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_wr_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write ready while busy");
	c_fatal: cover property (msg_valid && msg_type == 2'h3);
	c_nonfatal: cover property (msg_valid && msg_type == 2'h1);
	c_cor: cover property (msg_valid && msg_type == 2'h0);
endmodule : pcaer_props
bind pcaer_top pcaer_props pcaer_props_inst (.aclk(aclk), .aresetn(aresetn),
	.unc_event(unc_event), .cor_event(cor_event), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .msg_valid(msg_valid), .msg_type(msg_type),
	.ecrc_gen_en(ecrc_gen_en), .ecrc_chk_en(ecrc_chk_en));

// ---- tb/pcaer_rc_model.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Counts error messages by kind as the receiving side sees them.
module pcaer_rc_model (
	input wire logic aclk,
	input wire logic msg_valid,
	input wire logic [1:0] msg_type,
	output logic [23:0] n_msg
);
	initial
	begin
		n_msg = '0;
	end
	always @(posedge aclk)
	begin
		if (msg_valid && msg_type == 2'h0)
			n_msg <= n_msg + 24'h00_0001;
		if (msg_valid && msg_type == 2'h1)
			n_msg <= n_msg + 24'h00_0100;
		if (msg_valid && msg_type == 2'h3)
			n_msg <= n_msg + 24'h01_0000;
	end
endmodule : pcaer_rc_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	logic aclk, aresetn, link_reset, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic msg_valid, gen_en, chk_en, irq;
	logic [11:0] awa, ara;
	logic [31:0] wd, rd, got;
	logic [1:0] bresp, rresp, msg_type, resp;
	logic [20:0] unc;
	logic [12:0] cor;
	logic [127:0] hdr;
	logic [3:0] ws;
	logic [23:0] n_msg, exp_n;
	logic [11:0] ra [5] = '{12'h108, 12'h10c, 12'h110, 12'h114, 12'h118};
	logic [31:0] rv0 [5] = '{'0, 32'h0006_2011, '0, '0, 32'h0000_00a0};
	logic [31:0] cm [5] = '{32'h1, 32'h40, 32'h80, 32'h100, 32'h1000};
	int num_errors, cmp_count;
	pcaer_top pcaer_top_inst (.aclk(aclk), .aresetn(aresetn), .link_reset(link_reset),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.unc_event(unc), .cor_event(cor), .err_header(hdr), .msg_valid(msg_valid),
		.msg_type(msg_type), .ecrc_gen_en(gen_en), .ecrc_chk_en(chk_en), .irq(irq));
	pcaer_rc_model pcaer_rc_model_inst (.aclk(aclk), .msg_valid(msg_valid),
		.msg_type(msg_type), .n_msg(n_msg));
	////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tmo(input logic busy);
		if (busy)
		begin
			num_errors++;
			report_and_stop();
		end
	endtask : tmo
	task automatic wrt(input logic [11:0] a, input logic [31:0] d);
		int i;
		logic done;
		done = 1'h0;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		for (i = 0; i < 40 && !done; i++)
		begin
			@(posedge aclk);
			if (awr)
				awv <= 1'h0;
			if (wr)
				wv <= 1'h0;
			if (bv)
			begin
				resp = bresp;
				br <= 1'h0;
				done = 1'h1;
			end
		end
		tmo(!done);
	endtask : wrt
	task automatic rdt(input logic [11:0] a);
		int i;
		logic done;
		done = 1'h0;
		@(posedge aclk);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		for (i = 0; i < 40 && !done; i++)
		begin
			@(posedge aclk);
			if (arr)
				arv <= 1'h0;
			if (rv)
			begin
				got = rd;
				resp = rresp;
				rr <= 1'h0;
				done = 1'h1;
			end
		end
		tmo(!done);
	endtask : rdt
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		rdt(a);
		check(got, e);
	endtask : rc
	// One cycle of events, then two idle edges so the message has landed.
	task automatic ev(input logic [20:0] u, input logic [12:0] c);
		@(posedge aclk);
		unc <= u;
		cor <= c;
		@(posedge aclk);
		unc <= '0;
		cor <= '0;
		repeat (2) @(posedge aclk);
	endtask : ev
	////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	initial
	begin
		{aresetn, link_reset, awv, wv, br, arv, rr, awa, ara, wd, unc, cor, exp_n} = '0;
		hdr = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
		ws = 4'hf;
		num_errors = 0;
		cmp_count = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		foreach (ra[k])
			rc(ra[k], rv0[k]);
		rdt(12'h200);
		check(resp, 2'h2);
		wrt(12'h200, '1);
		check(resp, 2'h2);
		wrt(12'h108, '1);
		rc(12'h108, 32'h001f_f011);
		ws <= 4'h2;
		wrt(12'h108, '0);
		ws <= 4'hf;
		rc(12'h108, 32'h001f_0011);
		wrt(12'h10c, '1);
		rc(12'h10c, 32'h001f_f011);
		wrt(12'h10c, 32'h0006_2011);
		wrt(12'h108, '0);
		wrt(12'h118, '1);
		check({gen_en, chk_en}, 2'h3);
		@(posedge aclk);
		link_reset <= 1'h1;
		@(posedge aclk);
		link_reset <= 1'h0;
		rc(12'h118, 32'h0000_01e0);
		foreach (cm[k])
		begin
			ev('0, cm[k][12:0]);
			exp_n += 24'h00_0001;
			rc(12'h110, cm[k]);
			wrt(12'h110, cm[k]);
			rc(12'h110, '0);
		end
		wrt(12'h114, '1);
		rc(12'h114, 32'h0000_11c1);
		ev('0, 13'h11c1);
		check(n_msg, exp_n);
		wrt(12'h114, '0);
		wrt(12'h134, 32'h3);
		wrt(12'h138, 32'h1);
		ev('0, 13'h1);
		check(irq, 1'h1);
		wrt(12'h134, 32'h1);
		check(irq, 1'h0);
		wrt(12'h138, '0);
		ev('0, 13'h1);
		check(irq, 1'h0);
		exp_n += 24'h00_0002;
		wrt(12'h130, 32'h1);
		ev(21'h0_1000, '0);
		exp_n += 24'h00_0100;
		rc(12'h118, 32'h0000_01ec);
		for (int k = 0; k < 4; k++)
			rc(12'h11c + 12'(4 * k), hdr[127 - 32 * k -: 32]);
		hdr <= ~hdr;
		ev(21'h0_0001, '0);
		exp_n += 24'h01_0000;
		rc(12'h11c, 32'h0011_2233);
		rc(12'h118, 32'h0000_01ec);
		wrt(12'h108, 32'h0008_0000);
		ev(21'h8_0000, '0);
		wrt(12'h108, 32'h0010_0000);
		ev(21'h10_0000, '0);
		check(n_msg, exp_n);
		ev(21'h8_0000, '0);
		wrt(12'h10c, 32'h0000_1000);
		ev(21'h0_1000, '0);
		exp_n += 24'h01_0100;
		wrt(12'h118, '0);
		ev(21'h8_0000, '0);
		check({gen_en, chk_en}, 2'h0);
		check(n_msg, exp_n);
		report_and_stop();
	end
endmodule : testbench
